// *** hdl/cfg_hdr_pkg.sv ***
package cfg_hdr_pkg;
  // Configuration offsets (dword aligned byte addresses)
  localparam logic [7:0] OFF_COMMAND_STATUS  = 8'h04;
  localparam logic [7:0] OFF_CLASS_REVISION  = 8'h08;
  localparam logic [7:0] OFF_LATENCY_LINE    = 8'h0c;
  // Command register bit positions
  localparam int CMD_WRITE_INVALIDATE_BIT   = 4;
  localparam int CMD_PARITY_RESPONSE_BIT    = 6;
  localparam int CMD_INT_DISABLE_BIT        = 10;
  // Status register bit positions
  localparam int STS_INT_STATUS_BIT         = 3;
  localparam int STS_CAP_LIST_BIT           = 4;
  localparam int STS_FAST_CLOCK_BIT         = 5;
  localparam int STS_USER_FEATURE_BIT       = 6;
  localparam int STS_BACK_TO_BACK_BIT       = 7;
  localparam int STS_DATA_PARITY_BIT        = 8;
  // Hardwired status values
  localparam logic       BACK_TO_BACK_CAPABLE    = 1'b0;
  localparam logic       USER_FEATURE_SUPPORT    = 1'b0;
  localparam logic       FAST_CLOCK_CAPABLE      = 1'b1;
  localparam logic       CAPABILITY_LIST_PRESENT = 1'b1;
  localparam logic [2:0] STATUS_RESERVED_LOW     = 3'h0;
  // Class code fields
  localparam logic [7:0] BASE_CLASS_FIELD          = 8'h0c;
  localparam logic [7:0] SUB_CLASS_FIELD           = 8'h00;
  localparam logic [7:0] PROGRAMMING_INTERFACE_FIELD = 8'h10;
  // Reset values
  localparam logic [15:0] LATENCY_LINE_RESET = 16'h0000;
  localparam logic [15:0] COMMAND_RESET      = 16'h0000;
  // Bus command encodings for initiated memory cycles
  localparam logic [3:0] BUS_CMD_MEM_READ       = 4'h6;
  localparam logic [3:0] BUS_CMD_MEM_WRITE      = 4'h7;
  localparam logic [3:0] BUS_CMD_MEM_READ_MULT  = 4'hc;
  localparam logic [3:0] BUS_CMD_MEM_READ_LINE  = 4'he;
  localparam logic [3:0] BUS_CMD_MEM_WRITE_INV  = 4'hf;
  // Request kinds from the internal DMA engine
  localparam logic [1:0] REQ_READ_SHORT = 2'h0;
  localparam logic [1:0] REQ_READ_LINE  = 2'h1;
  localparam logic [1:0] REQ_READ_MULT  = 2'h2;
  localparam logic [1:0] REQ_WRITE      = 2'h3;
endpackage

// *** hdl/cfg_hdr_regs.sv ***
`timescale 1ns/1ps
module cfg_hdr_regs
  import cfg_hdr_pkg::*;
#(
  parameter logic [7:0] SILICON_REVISION = 8'h5a // Arbitrary value
) (
  // Clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst,
  // Configuration access port
  input  wire logic        i_cfg_write,
  input  wire logic        i_cfg_read,
  input  wire logic [7:0]  i_cfg_addr,
  input  wire logic [3:0]  i_cfg_byte_en,
  input  wire logic [31:0] i_cfg_wdata,
  output logic [31:0]      o_cfg_rdata,
  output logic             o_cfg_rvalid,
  // Function events
  input  wire logic        i_int_condition,
  input  wire logic        i_perr_seen,
  input  wire logic        i_parity_error_detected,
  input  wire logic        i_status_clear_parity,
  // Initiator side
  input  wire logic        i_frame_start,
  input  wire logic        i_master_active,
  input  wire logic        i_gnt_n,
  input  wire logic        i_req_valid,
  input  wire logic [1:0]  i_req_kind,
  // Outputs to bus logic
  output logic             o_intx_n,
  output logic             o_perr_drive,
  output logic             o_end_transaction,
  output logic             o_latency_expired,
  output logic [3:0]       o_bus_cmd,
  output logic [7:0]       o_line_size,
  output logic [15:0]      o_command,
  output logic [15:0]      o_status
);

  // Register storage and internal state
  logic [15:0] command_reg;
  logic [15:0] latency_line_reg;
  logic        int_status_reg;
  logic        data_parity_reported_reg;
  logic [7:0]  latency_count_reg;
  logic [7:0]  latency_count_next;
  logic        expired_reg;
  // Combinational views and decodes
  logic [15:0] status_view;
  logic [31:0] class_view;
  logic [31:0] read_view;
  logic [7:0]  latency_field;
  logic [7:0]  line_size_field;
  logic        line_size_usable;
  logic        write_command;
  logic        write_latency;
  logic        parity_set;
  logic        parity_clear;
  logic        latency_reached;
  logic [3:0]  bus_cmd_next;

  // Field positions must sit inside the 16-bit command and status views
  if ((STS_DATA_PARITY_BIT > 15) || (CMD_INT_DISABLE_BIT > 15)) begin : g_field_check
    $error("Command or status bit position lies outside its register");
  end

  // Address decode; exact dword match, no aliasing
  assign write_command = i_cfg_write && (i_cfg_addr == OFF_COMMAND_STATUS);
  assign write_latency = i_cfg_write && (i_cfg_addr == OFF_LATENCY_LINE);

  // Field slices of the latency and line size register
  assign latency_field   = latency_line_reg[15:8];
  assign line_size_field = latency_line_reg[7:0];
  // Zero line size makes line commands meaningless, so those fall back
  assign line_size_usable = (line_size_field != 8'h00);

  // Fixed class code with revision, no storage at all
  assign class_view = {BASE_CLASS_FIELD, SUB_CLASS_FIELD,
                       PROGRAMMING_INTERFACE_FIELD, SILICON_REVISION};

  // Status view; upper error bits live outside this block and read zero here
  always_comb begin
    status_view                       = 16'h0000;
    status_view[STS_DATA_PARITY_BIT]  = data_parity_reported_reg;
    status_view[STS_BACK_TO_BACK_BIT] = BACK_TO_BACK_CAPABLE;
    status_view[STS_USER_FEATURE_BIT] = USER_FEATURE_SUPPORT;
    status_view[STS_FAST_CLOCK_BIT]   = FAST_CLOCK_CAPABLE;
    status_view[STS_CAP_LIST_BIT]     = CAPABILITY_LIST_PRESENT;
    status_view[STS_INT_STATUS_BIT]   = int_status_reg;
    status_view[2:0]                  = STATUS_RESERVED_LOW;
  end

  // Parity flag terms; the set needs all three conditions in one cycle
  assign parity_set   = i_perr_seen && i_master_active
                        && command_reg[CMD_PARITY_RESPONSE_BIT];
  assign parity_clear = (write_command && i_cfg_byte_en[3]
                         && i_cfg_wdata[16 + STS_DATA_PARITY_BIT])
                        || i_status_clear_parity;

  // Compare on the advanced count, so expiry lands when it meets the field
  // A zero field therefore expires after the first counted cycle
  assign latency_count_next = latency_count_reg + 8'h01;
  assign latency_reached    = (latency_count_next >= latency_field);

  // Bus command for a new request; line commands need a usable line size
  always_comb begin
    case (i_req_kind)
      REQ_WRITE: begin
        if (command_reg[CMD_WRITE_INVALIDATE_BIT] && line_size_usable) begin
          bus_cmd_next = BUS_CMD_MEM_WRITE_INV;
        end else begin
          bus_cmd_next = BUS_CMD_MEM_WRITE;
        end
      end
      REQ_READ_LINE: begin
        if (line_size_usable) begin
          bus_cmd_next = BUS_CMD_MEM_READ_LINE;
        end else begin
          bus_cmd_next = BUS_CMD_MEM_READ;
        end
      end
      REQ_READ_MULT: begin
        if (line_size_usable) begin
          bus_cmd_next = BUS_CMD_MEM_READ_MULT;
        end else begin
          bus_cmd_next = BUS_CMD_MEM_READ;
        end
      end
      default: begin
        bus_cmd_next = BUS_CMD_MEM_READ;
      end
    endcase
  end

  // Read mux; unmapped offsets return zero
  always_comb begin
    case (i_cfg_addr)
      OFF_COMMAND_STATUS: read_view = {status_view, command_reg};
      OFF_CLASS_REVISION: read_view = class_view;
      OFF_LATENCY_LINE:   read_view = {16'h0000, latency_line_reg};
      default:            read_view = 32'h0000_0000;
    endcase
  end

  // Command register, byte lanes 0 and 1 only; upper lanes belong to status
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      command_reg <= COMMAND_RESET;
    end else if (write_command) begin
      if (i_cfg_byte_en[0]) begin
        command_reg[7:0] <= i_cfg_wdata[7:0];
      end
      if (i_cfg_byte_en[1]) begin
        command_reg[15:8] <= i_cfg_wdata[15:8];
      end
    end
  end

  // Latency timer and line size; offset 08h has no write path at all
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      latency_line_reg <= LATENCY_LINE_RESET;
    end else if (write_latency) begin
      if (i_cfg_byte_en[0]) begin
        latency_line_reg[7:0] <= i_cfg_wdata[7:0];
      end
      if (i_cfg_byte_en[1]) begin
        latency_line_reg[15:8] <= i_cfg_wdata[15:8];
      end
    end
  end

  // Interrupt status follows the condition; the disable bit masks only the pin
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      int_status_reg <= 1'b0;
    end else begin
      int_status_reg <= i_int_condition;
    end
  end

  // Sticky parity flag; a set in the same cycle as a clear wins
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      data_parity_reported_reg <= 1'b0;
    end else if (parity_set) begin
      data_parity_reported_reg <= 1'b1;
    end else if (parity_clear) begin
      data_parity_reported_reg <= 1'b0;
    end
  end

  // Latency count restarts on own FRAME and advances each master cycle until expiry
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      latency_count_reg <= 8'h00;
    end else if (i_frame_start) begin
      latency_count_reg <= 8'h00;
    end else if (i_master_active && !expired_reg) begin
      latency_count_reg <= latency_count_next;
    end
  end

  // Expiry flag; held until a new FRAME or the end of mastership
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      expired_reg <= 1'b0;
    end else if (i_frame_start) begin
      expired_reg <= 1'b0;
    end else if (i_master_active && !expired_reg && latency_reached) begin
      expired_reg <= 1'b1;
    end else if (!i_master_active) begin
      expired_reg <= 1'b0;
    end
  end

  // Termination request once expired and grant withdrawn
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_end_transaction <= 1'b0;
    end else begin
      o_end_transaction <= expired_reg && i_master_active && i_gnt_n;
    end
  end

  // Expiry mirror for the bus logic
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_latency_expired <= 1'b0;
    end else begin
      o_latency_expired <= expired_reg;
    end
  end

  // Bus command register, loaded on each request and held between them
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_bus_cmd <= BUS_CMD_MEM_READ;
    end else if (i_req_valid) begin
      o_bus_cmd <= bus_cmd_next;
    end
  end

  // Interrupt pin, active low; one stage behind the status bit
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_intx_n <= 1'b1;
    end else begin
      o_intx_n <= !(int_status_reg && !command_reg[CMD_INT_DISABLE_BIT]);
    end
  end

  // Parity error drive, only with parity response enabled
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_perr_drive <= 1'b0;
    end else begin
      o_perr_drive <= i_parity_error_detected
                      && command_reg[CMD_PARITY_RESPONSE_BIT];
    end
  end

  // Line size mirror for the initiator
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_line_size <= 8'h00;
    end else begin
      o_line_size <= line_size_field;
    end
  end

  // Command mirror, one cycle late
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_command <= COMMAND_RESET;
    end else begin
      o_command <= command_reg;
    end
  end

  // Status mirror, one cycle late
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_status <= 16'h0000;
    end else begin
      o_status <= status_view;
    end
  end

  // Read valid pulse, one cycle after the strobe
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_rvalid <= 1'b0;
    end else begin
      o_cfg_rvalid <= i_cfg_read;
    end
  end

  // Read data, held until the next read so a slow host still sees it
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_cfg_rdata <= 32'h0000_0000;
    end else if (i_cfg_read) begin
      o_cfg_rdata <= read_view;
    end
  end

endmodule

// *** tb/cfg_hdr_checker_asserts.sv ***
`timescale 1ns/1ps
module cfg_hdr_checker (
  // Clock, reset and inputs
  input wire logic        i_clock,
  input wire logic        i_rst,
  input wire logic        i_cfg_read,
  input wire logic [7:0]  i_cfg_addr,
  input wire logic        i_int_condition,
  input wire logic        i_perr_seen,
  input wire logic        i_parity_error_detected,
  input wire logic        i_master_active,
  input wire logic        i_gnt_n,
  input wire logic        i_req_valid,
  // Watched outputs
  input wire logic [31:0] o_cfg_rdata,
  input wire logic        o_intx_n,
  input wire logic        o_perr_drive,
  input wire logic        o_end_transaction,
  input wire logic [3:0]  o_bus_cmd,
  input wire logic [7:0]  o_line_size,
  input wire logic [15:0] o_command,
  input wire logic [15:0] o_status
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Fixed fields, read back after the mirrors settle
  a_class_fixed: assert property (
    i_cfg_read && i_cfg_addr == 8'h08 |=> o_cfg_rdata[31:8] == 24'h0c0010)
    else $error("class code wrong");
  a_status_fixed: assert property (
    !$past(i_rst) && !$past(i_rst, 2) |-> (o_status[7:0] & 8'hf7) == 8'h30)
    else $error("hardwired status wrong");
  // Pin needs the condition two stages back
  a_intx_cause: assert property (!o_intx_n |-> $past(i_int_condition, 2))
    else $error("intx without cause");
  a_int_tracks: assert property (i_int_condition [*4] |-> o_status[3])
    else $error("int status lost");
  a_parity_cause: assert property (
    $rose(o_status[8]) |-> $past(i_perr_seen, 2) && $past(i_master_active, 2)
    && $past(o_command[6]))
    else $error("parity flag without cause");
  a_perr_cause: assert property (
    o_perr_drive |-> $past(i_parity_error_detected) && o_command[6])
    else $error("perr without error");
  a_end_needs_gnt: assert property (
    o_end_transaction |-> $past(i_gnt_n) && $past(i_master_active))
    else $error("ended while granted");
  a_mwi_gated: assert property (
    $past(i_req_valid) && o_bus_cmd == 4'hf |-> o_command[4] && o_line_size != 8'h00)
    else $error("mwi not enabled");
  // Main scenarios reached
  c_intx: cover property (!o_intx_n);
  c_end: cover property (o_end_transaction);
  c_mwi: cover property (o_bus_cmd == 4'hf);
  c_parity: cover property ($rose(o_status[8]));
endmodule

// *** tb/pci_agent_model.sv ***
`timescale 1ns/1ps
module pci_agent_model (
  input wire logic i_clock,
  input wire logic i_grant_on,
  input wire logic i_perr_req,
  output logic     o_gnt_n,
  output logic     o_perr_seen
);
  // Arbiter and other agents answer one edge late, never early
  always @(posedge i_clock) begin
    o_gnt_n <= ~i_grant_on;
    o_perr_seen <= i_perr_req;
  end
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
  logic        i_clock = 0, i_rst = 1, wr = 0, rd = 0, intc = 0, ped = 0, fs = 0, ma = 0;
  logic        rv = 0, gon = 0, pq = 0, gnt_n, perr, intx_n, perr_drv, endt, lexp, rvalid;
  logic [1:0]  rk = 0;
  logic [3:0]  be = 0, bcmd;
  logic [3:0]  ecmd [4] = '{4'h6, 4'he, 4'hc, 4'hf};
  logic [7:0]  addr = 0, lsz;
  logic [15:0] cmd, sts;
  logic [31:0] wdata = 0, rdata;
  int          err_count = 0, cmp_count = 0;
  always #2 i_clock = ~i_clock;
  pci_agent_model AGENT (.i_clock, .i_grant_on(gon), .i_perr_req(pq), .o_gnt_n(gnt_n),
    .o_perr_seen(perr));
  cfg_hdr_regs #(.SILICON_REVISION(8'h3c)) DUT (.i_clock, .i_rst, .i_cfg_write(wr),
    .i_cfg_read(rd), .i_cfg_addr(addr), .i_cfg_byte_en(be), .i_cfg_wdata(wdata),
    .o_cfg_rdata(rdata), .o_cfg_rvalid(rvalid), .i_int_condition(intc), .i_perr_seen(perr),
    .i_parity_error_detected(ped), .i_status_clear_parity(1'b0), .i_frame_start(fs),
    .i_master_active(ma), .i_gnt_n(gnt_n), .i_req_valid(rv), .i_req_kind(rk),
    .o_intx_n(intx_n), .o_perr_drive(perr_drv), .o_end_transaction(endt),
    .o_latency_expired(lexp), .o_bus_cmd(bcmd), .o_line_size(lsz), .o_command(cmd),
    .o_status(sts));
  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Config cycles: strobe for one edge, launched at the falling edge
  task automatic wrr(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
    @(negedge i_clock);
    addr = a;
    be = b;
    wdata = d;
    wr = 1;
    @(negedge i_clock);
    wr = 0;
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(negedge i_clock);
    addr = a;
    rd = 1;
    @(negedge i_clock);
    rd = 0;
    chk({31'h0, rvalid}, 32'h1);
    chk(rdata & m, e);
  endtask
  task automatic req(input logic [1:0] k, input logic [3:0] e);
    @(negedge i_clock);
    rk = k;
    rv = 1;
    @(negedge i_clock);
    rv = 0;
    chk({28'h0, bcmd}, {28'h0, e});
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Watchdog well beyond the roughly 80 cycles the tests need
  initial begin
    #8000;
    err_count++;
    results();
  end
  initial begin
    repeat (4) @(negedge i_clock);
    i_rst = 0;
    rdc(8'h0c, 32'hffff, 32'h0);
    rdc(8'h08, 32'hffffffff, 32'h0c00103c);
    rdc(8'h04, 32'h00f70000, 32'h00300000);
    wrr(8'h08, 4'hf, 32'hffffffff);
    rdc(8'h08, 32'hffffffff, 32'h0c00103c);
    wrr(8'h04, 4'h4, 32'h00ff0000);
    rdc(8'h04, 32'h00f70000, 32'h00300000);
    rdc(8'h20, 32'hffffffff, 32'h0);
    $display("register test done");
    intc = 1;
    repeat (3) @(negedge i_clock);
    chk({31'h0, intx_n}, 32'h0);
    wrr(8'h04, 4'h3, 32'h0400);
    repeat (2) @(negedge i_clock);
    chk({30'h0, intx_n, sts[3]}, 32'h3);
    intc = 0;
    $display("interrupt test done");
    wrr(8'h04, 4'h3, 32'h0050);
    wrr(8'h0c, 4'h3, 32'h0410);
    rdc(8'h0c, 32'hffff, 32'h0410);
    chk({16'h0, cmd}, 32'h0050);
    chk({24'h0, lsz}, 32'h10);
    for (int k = 0; k < 4; k++) req(k[1:0], ecmd[k]);
    wrr(8'h04, 4'h3, 32'h0040);
    req(2'h3, 4'h7);
    $display("command test done");
    gon = 1;
    fs = 1;
    ma = 1;
    @(negedge i_clock);
    fs = 0;
    repeat (8) @(negedge i_clock);
    chk({30'h0, lexp, endt}, 32'h2);
    gon = 0;
    repeat (3) @(negedge i_clock);
    chk({31'h0, endt}, 32'h1);
    fs = 1;
    @(negedge i_clock);
    fs = 0;
    @(negedge i_clock);
    chk({31'h0, lexp}, 32'h0);
    $display("latency test done");
    pq = 1;
    @(negedge i_clock);
    pq = 0;
    repeat (4) @(negedge i_clock);
    chk({31'h0, sts[8]}, 32'h1);
    wrr(8'h04, 4'h8, 32'h01000000);
    ma = 0;
    pq = 1;
    @(negedge i_clock);
    pq = 0;
    repeat (4) @(negedge i_clock);
    chk({31'h0, sts[8]}, 32'h0);
    ped = 1;
    @(negedge i_clock);
    chk({31'h0, perr_drv}, 32'h1);
    ped = 0;
    // Parity response disabled: no flag and no PERR drive
    wrr(8'h04, 4'h3, 32'h0000);
    ma = 1;
    pq = 1;
    ped = 1;
    @(negedge i_clock);
    pq = 0;
    @(negedge i_clock);
    ped = 0;
    chk({31'h0, perr_drv}, 32'h0);
    repeat (3) @(negedge i_clock);
    chk({31'h0, sts[8]}, 32'h0);
    $display("parity test done");
    results();
  end
endmodule
bind cfg_hdr_regs cfg_hdr_checker CHK (.i_clock, .i_rst, .i_cfg_read, .i_cfg_addr,
  .i_int_condition, .i_perr_seen, .i_parity_error_detected, .i_master_active, .i_gnt_n,
  .i_req_valid, .o_cfg_rdata, .o_intx_n, .o_perr_drive, .o_end_transaction, .o_bus_cmd,
  .o_line_size, .o_command, .o_status);
